// file: core/swmal_params.svh
`ifndef SWMAL_PARAMS_SVH
`define SWMAL_PARAMS_SVH

// Table geometry
`define SWMAL_TBL_DEPTH   1024
`define SWMAL_AW          10
`define SWMAL_STAMP_W     3

// Aging time base
`define SWMAL_CLK_HZ      20000000
`define SWMAL_CLK_NS      50
`define SWMAL_AGE_TICK_S  75
`define SWMAL_AGE_TICK_CYC (`SWMAL_AGE_TICK_S * `SWMAL_CLK_HZ)
`define SWMAL_AGE_LIMIT   3'h4

// Legal length window in bytes
`define SWMAL_LEN_MIN     11'h040
`define SWMAL_LEN_STD     11'h5EE
`define SWMAL_LEN_1536    11'h600
`define SWMAL_LEN_2000    11'h7D0

// Half-duplex timing in bit times and ns per bit
`define SWMAL_IPG_BITS    96
`define SWMAL_SLOT_BITS   512
`define SWMAL_BIT_NS_100  10
`define SWMAL_BIT_NS_10   100
`define SWMAL_CEIL_CYC(b, ns) (((b) * (ns) + `SWMAL_CLK_NS - 1) / `SWMAL_CLK_NS)
`define SWMAL_MAX_COLL    5'h10
`define SWMAL_BO_LIMIT    5'h0A

// Host-facing port number
`define SWMAL_HOST_PORT   2'h2

`endif

// file: core/swmal_pkg.sv
package swmal_pkg;

  // Egress port set, one bit per switch port
  typedef logic [2:0] swmal_pset_type;

  // Received frame descriptor from the port receive path
  typedef struct packed {
    logic [7:0]     tag;
    logic [47:0]    sa;
    logic [47:0]    da;
    logic [1:0]     src_port;
    logic [10:0]    len;
    logic           rx_err;
    logic           is_pause;
    logic           igmp;
    logic           static_hit;
    swmal_pset_type static_set;
    swmal_pset_type vlan_set;
  } swmal_rx_type;

  // Forwarding answer to the queue manager
  typedef struct packed {
    logic [7:0]     tag;
    logic           drop;
    swmal_pset_type pset;
  } swmal_fwd_type;

  // Second-stage port policy
  typedef struct packed {
    swmal_pset_type stp_fwd;
    swmal_pset_type pvlan;
    swmal_pset_type mirror_src;
    swmal_pset_type sniffer;
  } swmal_cfg_type;

  // Dynamic table entry
  typedef struct packed {
    logic        valid;
    logic [47:0] mac;
    logic [1:0]  port;
    logic [2:0]  stamp;
  } swmal_entry_type;

  typedef enum logic [2:0] {ENG_INIT, ENG_IDLE, ENG_SCAN, ENG_DECIDE, ENG_PUSH} swmal_eng_type;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_BACK} swmal_tx_type;

endpackage

// file: core/swmal_table_ram.sv
`include "swmal_params.svh"

module swmal_table_ram (
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_n,
  // Read port
  input  wire logic [`SWMAL_AW-1:0]   i_rd_addr,
  output swmal_pkg::swmal_entry_type  o_rd_data,
  // Write port
  input  wire logic                   i_wr_en,
  input  wire logic [`SWMAL_AW-1:0]   i_wr_addr,
  input  swmal_pkg::swmal_entry_type  i_wr_data
);

  swmal_pkg::swmal_entry_type mem [`SWMAL_TBL_DEPTH];

  // Storage write
  always_ff @(posedge i_clk_sys) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Registered read
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule // swmal_table_ram

// file: core/swmal_core.sv
`include "swmal_params.svh"

module swmal_core #(
  parameter int unsigned AGE_TICK_CYC = `SWMAL_AGE_TICK_CYC
) (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  // Control bits
  input  wire logic              i_aging_en,
  input  wire logic              i_len_2000_en,
  input  wire logic              i_len_1536_en,
  input  wire logic              i_half_duplex,
  input  wire logic              i_speed_100,
  input  swmal_pkg::swmal_cfg_type i_cfg,
  // Receive descriptors
  input  wire logic              i_rx_valid,
  input  swmal_pkg::swmal_rx_type i_rx,
  output logic                   o_rx_ready,
  // Forwarding answers
  output logic                   o_fwd_valid,
  output swmal_pkg::swmal_fwd_type o_fwd,
  input  wire logic              i_fwd_ready,
  output logic                   o_pause_seen,
  // Transmit queue and line
  input  wire logic              i_txq_valid,
  output logic                   o_txq_take,
  input  wire logic              i_tx_last,
  input  wire logic              i_crs,
  input  wire logic              i_col,
  output logic                   o_tx_en,
  output logic                   o_tx_ok,
  output logic                   o_tx_drop_late,
  output logic                   o_tx_drop_excess
);

  // Entry age modulo the stamp width
  function automatic logic [2:0] age_of(input logic [2:0] now_v, input logic [2:0] st_v);
    age_of = 3'(now_v - st_v);
  endfunction

  // Port number to port set
  function automatic swmal_pkg::swmal_pset_type onehot(input logic [1:0] p);
    onehot = 3'(4'h1 << p);
  endfunction

  swmal_pkg::swmal_eng_type   st;
  swmal_pkg::swmal_rx_type    rx;
  swmal_pkg::swmal_entry_type rd_data;
  swmal_pkg::swmal_entry_type wr_data;
  swmal_pkg::swmal_fwd_type   res;
  swmal_pkg::swmal_fwd_type   spare;
  logic                       spare_v;
  logic [10:0]                ptr;
  logic [9:0]                 age_ptr;
  logic [9:0]                 rd_addr_q;
  logic                       rd_vld;
  logic                       rd_scan;
  logic                       sa_hit;
  logic [9:0]                 sa_idx;
  logic                       da_hit;
  logic [1:0]                 da_port;
  logic                       free_fnd;
  logic [9:0]                 free_idx;
  logic [9:0]                 old_idx;
  logic [2:0]                 old_age;
  logic [2:0]                 now;
  logic [31:0]                tick_cnt;

  // Table read and write selection
  wire        take      = (st == swmal_pkg::ENG_IDLE) && i_rx_valid;
  wire        issue_age = (st == swmal_pkg::ENG_IDLE) && !i_rx_valid;
  wire        issue_scn = (st == swmal_pkg::ENG_SCAN) && !ptr[10];
  wire [9:0]  rd_addr   = (st == swmal_pkg::ENG_SCAN) ? ptr[9:0] : age_ptr;
  wire        age_kill  = rd_vld && rd_data.valid && i_aging_en &&
                          (age_of(now, rd_data.stamp) >= `SWMAL_AGE_LIMIT);
  wire        live      = rd_vld && rd_scan && rd_data.valid && !age_kill;
  wire        slot_free = rd_vld && rd_scan && (!rd_data.valid || age_kill);
  wire        last_rd   = rd_vld && rd_scan && (rd_addr_q == 10'h3FF);
  wire [10:0] len_max   = i_len_2000_en ? `SWMAL_LEN_2000 :
                          i_len_1536_en ? `SWMAL_LEN_1536 : `SWMAL_LEN_STD;
  wire        good      = !rx.rx_err && (rx.len >= `SWMAL_LEN_MIN) && (rx.len <= len_max);
  wire [9:0]  learn_idx = sa_hit ? sa_idx : (free_fnd ? free_idx : old_idx);
  wire        upd_wr    = (st == swmal_pkg::ENG_DECIDE) && good;
  wire        wr_en     = upd_wr || age_kill || (st == swmal_pkg::ENG_INIT);
  wire [9:0]  wr_addr   = (st == swmal_pkg::ENG_INIT) ? ptr[9:0] :
                          (upd_wr ? learn_idx : rd_addr_q);

  // New or refreshed entry contents
  always_comb begin
    wr_data = '0;
    if (upd_wr) begin
      wr_data.valid = 1'b1;
      wr_data.mac   = rx.sa;
      wr_data.port  = rx.src_port;
      wr_data.stamp = now;
    end
  end

  swmal_table_ram u_table (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_rd_addr (rd_addr),
    .o_rd_data (rd_data),
    .i_wr_en   (wr_en),
    .i_wr_addr (wr_addr),
    .i_wr_data (wr_data)
  );

  // Forwarding stage one: static, dynamic, flood within VLAN
  wire                        local_f = !rx.static_hit && da_hit && (da_port == rx.src_port);
  wire swmal_pkg::swmal_pset_type s1 = (rx.static_hit ? rx.static_set :
                                       (da_hit ? onehot(da_port) : rx.vlan_set)) &
                                       rx.vlan_set;
  // Forwarding stage two: spanning tree, snooping, port VLAN, mirror
  wire swmal_pkg::swmal_pset_type s2a = (rx.igmp ? onehot(`SWMAL_HOST_PORT) : s1) &
                                        i_cfg.stp_fwd & i_cfg.pvlan;
  wire swmal_pkg::swmal_pset_type s2  = (s2a | (i_cfg.mirror_src[rx.src_port] ?
                                        i_cfg.sniffer : 3'h0)) & ~onehot(rx.src_port);
  wire                        drop    = !good || rx.is_pause || local_f;

  // Time base for stamps, frozen while aging is off
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt <= 32'h0;
      now      <= 3'h0;
    end else if (i_aging_en) begin
      tick_cnt <= (tick_cnt >= AGE_TICK_CYC - 1) ? 32'h0 : tick_cnt + 32'h1;
      if (tick_cnt >= AGE_TICK_CYC - 1) begin
        now <= now + 3'h1;
      end
    end
  end

  // Read pipeline tracking
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_vld    <= 1'b0;
      rd_scan   <= 1'b0;
      rd_addr_q <= 10'h0;
      age_ptr   <= 10'h0;
    end else begin
      rd_vld    <= issue_age || issue_scn;
      rd_scan   <= issue_scn;
      rd_addr_q <= rd_addr;
      if (issue_age) begin
        age_ptr <= age_ptr + 10'h1;
      end
    end
  end

  // Scan accumulation over the whole table
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {sa_hit, da_hit, free_fnd, sa_idx, da_port, free_idx, old_idx, old_age} <= '0;
    end else if (take) begin
      {sa_hit, da_hit, free_fnd, sa_idx, da_port, free_idx, old_idx, old_age} <= '0;
    end else begin
      if (live && rd_data.mac == rx.sa) begin
        sa_hit <= 1'b1;
        sa_idx <= rd_addr_q;
      end
      if (live && rd_data.mac == rx.da) begin
        da_hit  <= 1'b1;
        da_port <= rd_data.port;
      end
      if (slot_free && !free_fnd) begin
        free_fnd <= 1'b1;
        free_idx <= rd_addr_q;
      end
      if (live && age_of(now, rd_data.stamp) > old_age) begin
        old_age <= age_of(now, rd_data.stamp);
        old_idx <= rd_addr_q;
      end
    end
  end

  // Lookup engine sequencing
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st           <= swmal_pkg::ENG_INIT;
      ptr          <= 11'h0;
      rx           <= '0;
      res          <= '0;
      o_rx_ready   <= 1'b0;
      o_pause_seen <= 1'b0;
    end else begin
      o_pause_seen <= 1'b0;
      unique case (st)
        swmal_pkg::ENG_INIT: begin
          ptr <= ptr + 11'h1;
          if (ptr[9:0] == 10'h3FF) begin
            st         <= swmal_pkg::ENG_IDLE;
            o_rx_ready <= 1'b1;
          end
        end
        swmal_pkg::ENG_IDLE: begin
          if (take) begin
            rx         <= i_rx;
            ptr        <= 11'h0;
            o_rx_ready <= 1'b0;
            st         <= swmal_pkg::ENG_SCAN;
          end
        end
        swmal_pkg::ENG_SCAN: begin
          if (issue_scn) begin
            ptr <= ptr + 11'h1;
          end
          if (last_rd) begin
            st <= swmal_pkg::ENG_DECIDE;
          end
        end
        swmal_pkg::ENG_DECIDE: begin
          res.tag      <= rx.tag;
          res.drop     <= drop;
          res.pset     <= drop ? 3'h0 : s2;
          o_pause_seen <= rx.is_pause && good;
          st           <= swmal_pkg::ENG_PUSH;
        end
        swmal_pkg::ENG_PUSH: begin
          if (!spare_v) begin
            st         <= swmal_pkg::ENG_IDLE;
            o_rx_ready <= 1'b1;
          end
        end
      endcase
    end
  end

  // Two-entry answer buffer: head drives the outputs, spare absorbs stalls
  wire push = (st == swmal_pkg::ENG_PUSH) && !spare_v;
  wire pop  = o_fwd_valid && i_fwd_ready;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fwd_valid <= 1'b0;
      o_fwd       <= '0;
      spare_v     <= 1'b0;
      spare       <= '0;
    end else if (!o_fwd_valid || pop) begin
      o_fwd_valid <= spare_v || push;
      o_fwd       <= spare_v ? spare : res;
      spare_v     <= spare_v && push;
      spare       <= res;
    end else if (push) begin
      spare_v <= 1'b1;
      spare   <= res;
    end
  end

  // Half-duplex transmit timing
  swmal_pkg::swmal_tx_type tx_st;
  logic [7:0]  gap_cnt;
  logic [10:0] tx_cyc;
  logic [4:0]  coll_cnt;
  logic        pend;
  logic [9:0]  lfsr;
  logic [9:0]  slot_left;
  logic [10:0] slot_tmr;
  wire  [7:0]  ipg_cyc  = i_speed_100 ? 8'(`SWMAL_CEIL_CYC(`SWMAL_IPG_BITS, `SWMAL_BIT_NS_100)) :
                                        8'(`SWMAL_CEIL_CYC(`SWMAL_IPG_BITS, `SWMAL_BIT_NS_10));
  wire  [10:0] slot_cyc = i_speed_100 ? 11'(`SWMAL_CEIL_CYC(`SWMAL_SLOT_BITS, `SWMAL_BIT_NS_100)) :
                                        11'(`SWMAL_CEIL_CYC(`SWMAL_SLOT_BITS, `SWMAL_BIT_NS_10));
  wire         gap_ok   = (gap_cnt >= ipg_cyc) && !(i_half_duplex && i_crs);
  wire  [4:0]  coll_nx  = coll_cnt + 5'h1;
  wire  [9:0]  bo_mask  = (coll_nx >= `SWMAL_BO_LIMIT) ? 10'h3FF :
                          10'((11'h1 << coll_nx) - 11'h1);

  // Gap restarts on own carrier or, in half duplex, on line carrier
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_cnt <= 8'h0;
      lfsr    <= 10'h1;
    end else begin
      lfsr <= {lfsr[8:0], lfsr[9] ^ lfsr[6]};
      if (o_tx_en || (i_half_duplex && i_crs)) begin
        gap_cnt <= 8'h0;
      end else if (gap_cnt != 8'hFF) begin
        gap_cnt <= gap_cnt + 8'h1;
      end
    end
  end

  // Transmit attempt, collision and back-off sequencing
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_st <= swmal_pkg::TX_IDLE;
      {o_tx_en, o_txq_take, o_tx_ok, o_tx_drop_late, o_tx_drop_excess, pend} <= '0;
      {tx_cyc, coll_cnt, slot_left, slot_tmr} <= '0;
    end else begin
      {o_txq_take, o_tx_ok, o_tx_drop_late, o_tx_drop_excess} <= '0;
      unique case (tx_st)
        swmal_pkg::TX_IDLE: begin
          if (gap_ok && (pend || i_txq_valid)) begin
            if (!pend) begin
              o_txq_take <= 1'b1;
              coll_cnt   <= 5'h0;
            end
            pend    <= 1'b1;
            o_tx_en <= 1'b1;
            tx_cyc  <= 11'h0;
            tx_st   <= swmal_pkg::TX_SEND;
          end
        end
        swmal_pkg::TX_SEND: begin
          if (tx_cyc != 11'h7FF) begin
            tx_cyc <= tx_cyc + 11'h1;
          end
          if (i_half_duplex && i_col) begin
            o_tx_en <= 1'b0;
            tx_st   <= swmal_pkg::TX_IDLE;
            if (tx_cyc >= slot_cyc) begin
              o_tx_drop_late <= 1'b1;
              pend           <= 1'b0;
            end else if (coll_nx == `SWMAL_MAX_COLL) begin
              coll_cnt         <= coll_nx;
              o_tx_drop_excess <= 1'b1;
              pend             <= 1'b0;
            end else begin
              coll_cnt  <= coll_nx;
              slot_left <= lfsr & bo_mask;
              slot_tmr  <= 11'h0;
              tx_st     <= swmal_pkg::TX_BACK;
            end
          end else if (i_tx_last) begin
            o_tx_en <= 1'b0;
            o_tx_ok <= 1'b1;
            pend    <= 1'b0;
            tx_st   <= swmal_pkg::TX_IDLE;
          end
        end
        swmal_pkg::TX_BACK: begin
          if (slot_left == 10'h0) begin
            tx_st <= swmal_pkg::TX_IDLE;
          end else if (slot_tmr >= slot_cyc - 11'h1) begin
            slot_tmr  <= 11'h0;
            slot_left <= slot_left - 10'h1;
          end else begin
            slot_tmr <= slot_tmr + 11'h1;
          end
        end
      endcase
    end
  end

  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  learn_gate_a: assert property ((st == swmal_pkg::ENG_DECIDE && !good) |-> !wr_en)
    else $error("bad frame wrote the table");
  evict_old_a: assert property ((upd_wr && !sa_hit && !free_fnd) |-> wr_addr == old_idx)
    else $error("full table did not evict oldest");
  migrate_port_a: assert property (upd_wr |-> wr_data.port == rx.src_port && wr_data.stamp == now)
    else $error("entry port or stamp not refreshed");
  age_hold_a: assert property (!i_aging_en |-> !age_kill ##1 $stable(now))
    else $error("aging ran while disabled");
  local_drop_a: assert property ((st == swmal_pkg::ENG_DECIDE && local_f) |=> res.drop && res.pset == 3'h0)
    else $error("local frame forwarded");
  pause_drop_a: assert property ((st == swmal_pkg::ENG_DECIDE && rx.is_pause) |=> res.drop)
    else $error("pause frame forwarded");
  err_drop_a: assert property ((st == swmal_pkg::ENG_DECIDE && !good) |=> res.drop ##1 res.pset == 3'h0)
    else $error("errored frame forwarded");
  tx_gap_a: assert property ($rose(o_tx_en) |-> $past(gap_cnt) >= $past(ipg_cyc))
    else $error("inter-packet gap too short");
  excess_drop_a: assert property (o_tx_drop_excess |-> coll_cnt == 5'h10 && !o_tx_en)
    else $error("excess drop at wrong count");
  late_drop_a: assert property (o_tx_drop_late |-> $past(tx_cyc) >= $past(slot_cyc))
    else $error("late drop before slot time");
  take_clear_a: assert property (o_txq_take |-> coll_cnt == 5'h0 ##1 o_tx_en)
    else $error("collision count not restarted");

endmodule // swmal_core

// file: tb/swmal_line_model.sv
module swmal_line_model (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  // Scenario controls
  input  wire logic       i_slow,
  input  wire logic       i_busy,
  input  wire logic [7:0] i_col_at,
  input  wire logic [7:0] i_len,
  // Line and fabric
  input  wire logic       i_tx_en,
  output logic            o_crs,
  output logic            o_col,
  output logic            o_tx_last,
  output logic            o_fwd_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cnt;
  logic [2:0] hold;
  logic [2:0] phase;
  logic       fired;

  // Carrier from own frame, foreign traffic or jam tail
  assign o_crs = i_busy | i_tx_en | (hold != 3'h0);
  // Slow fabric takes one answer in eight cycles
  assign o_fwd_ready = !i_slow || (phase == 3'h7);

  // Attempt timer, one collision per arming, end of frame
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt       <= 8'h00;
      hold      <= 3'h0;
      phase     <= 3'h0;
      fired     <= 1'b0;
      o_col     <= 1'b0;
      o_tx_last <= 1'b0;
    end else begin
      phase     <= phase + 3'h1;
      cnt       <= i_tx_en ? cnt + 8'h01 : 8'h00;
      o_col     <= i_tx_en && !fired && (i_col_at != 8'h00) && (cnt == i_col_at);
      o_tx_last <= i_tx_en && (cnt == i_len);
      hold      <= o_col ? 3'h6 : ((hold != 3'h0) ? hold - 3'h1 : 3'h0);
      fired     <= (i_col_at != 8'h00) && (fired || o_col);
    end
  end
endmodule // swmal_line_model

// file: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 2000;

  // Stimulus and observed signals
  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     aging_en = 1'b0;
  logic                     len_2000 = 1'b0;
  logic                     len_1536 = 1'b0;
  logic                     half = 1'b0;
  logic                     spd = 1'b1;
  logic                     slow = 1'b0;
  logic                     rx_valid = 1'b0;
  logic                     txq_valid = 1'b0;
  logic [7:0]               col_at = 8'h00;
  logic [7:0]               plen = 8'h28;
  logic [7:0]               tag = 8'h00;
  swmal_pkg::swmal_cfg_type cfg = '{3'h7, 3'h7, 3'h0, 3'h0};
  swmal_pkg::swmal_rx_type  rx = '0;
  swmal_pkg::swmal_fwd_type fwd;
  logic                     rx_ready, fwd_valid, fwd_ready, pause_seen, txq_take, tx_last;
  logic                     crs, col, tx_en, tx_ok, drop_late, drop_excess;
  int                       error_cnt = 0;
  int                       total_checks = 0;
  int                       pauses = 0, takes = 0, oks = 0, lates = 0, excs = 0;

  always #25 clk = ~clk;

  // Pulse counters
  always @(negedge clk) begin
    if (pause_seen === 1'b1) pauses++;
    if (txq_take === 1'b1) takes++;
    if (tx_ok === 1'b1) oks++;
    if (drop_late === 1'b1) lates++;
    if (drop_excess === 1'b1) excs++;
  end

  swmal_core #(.AGE_TICK_CYC(TICK)) u_swmal_core (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_aging_en(aging_en), .i_len_2000_en(len_2000),
    .i_len_1536_en(len_1536), .i_half_duplex(half), .i_speed_100(spd), .i_cfg(cfg),
    .i_rx_valid(rx_valid), .i_rx(rx), .o_rx_ready(rx_ready), .o_fwd_valid(fwd_valid),
    .o_fwd(fwd), .i_fwd_ready(fwd_ready), .o_pause_seen(pause_seen), .i_txq_valid(txq_valid),
    .o_txq_take(txq_take), .i_tx_last(tx_last), .i_crs(crs), .i_col(col), .o_tx_en(tx_en),
    .o_tx_ok(tx_ok), .o_tx_drop_late(drop_late), .o_tx_drop_excess(drop_excess));

  swmal_line_model u_swmal_line_model (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_slow(slow), .i_busy(1'b0), .i_col_at(col_at),
    .i_len(plen), .i_tx_en(tx_en), .o_crs(crs), .o_col(col), .o_tx_last(tx_last),
    .o_fwd_ready(fwd_ready));

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("Counts: %0d checks, %0d errors", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One descriptor in, one answer judged; fl is {err, pause, igmp}
  task automatic send(input logic [7:0] sa, input logic [7:0] da, input logic [1:0] port,
                      input logic [10:0] len, input logic [2:0] fl, input logic drop,
                      input logic [2:0] pset);
    int n;
    @(negedge clk);
    rx = '{tag, {40'h0200000000, sa}, {40'h0200000000, da}, port, len, fl[2], fl[1], fl[0],
           1'b0, 3'h0, 3'h7};
    rx_valid = 1'b1;
    n = 0;
    while (rx_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    rx_valid = 1'b0;
    n = 0;
    while (!(fwd_valid === 1'b1 && fwd_ready === 1'b1) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check("answer wait", 8'h00, {7'h00, n >= 3000});
    check("answer tag", tag, fwd.tag);
    check("answer drop", {7'h00, drop}, {7'h00, fwd.drop});
    check("answer set", {5'h00, pset}, {5'h00, fwd.pset});
    tag++;
    @(negedge clk);
  endtask

  task automatic t_learn();
    send(8'h0A, 8'h0F, 2'h0, 11'h064, 3'h0, 1'b0, 3'h6);
    send(8'h0B, 8'h0A, 2'h1, 11'h064, 3'h0, 1'b0, 3'h1);
    send(8'h0C, 8'h0A, 2'h0, 11'h064, 3'h0, 1'b1, 3'h0);
  endtask

  task automatic t_migrate();
    send(8'h0A, 8'h0F, 2'h1, 11'h064, 3'h0, 1'b0, 3'h5);
    send(8'h0C, 8'h0A, 2'h0, 11'h064, 3'h0, 1'b0, 3'h2);
  endtask

  task automatic t_errors();
    send(8'h0D, 8'h0F, 2'h2, 11'h064, 3'h4, 1'b1, 3'h0);
    send(8'h0C, 8'h0D, 2'h0, 11'h064, 3'h0, 1'b0, 3'h6);
    send(8'h0A, 8'h0F, 2'h0, 11'h064, 3'h4, 1'b1, 3'h0);
    send(8'h0C, 8'h0A, 2'h1, 11'h064, 3'h0, 1'b1, 3'h0);
  endtask

  task automatic t_lengths();
    logic [10:0] lens [9] = '{11'h03F, 11'h040, 11'h5EE, 11'h5EF, 11'h600, 11'h601,
                              11'h7D0, 11'h7D1, 11'h7D0};
    logic [1:0]  sel  [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    logic        bad  [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 9; i++) begin
      {len_2000, len_1536} = sel[i];
      send(8'h0C, 8'h0F, 2'h0, lens[i], 3'h0, bad[i], bad[i] ? 3'h0 : 3'h6);
    end
    {len_2000, len_1536} = 2'h0;
  endtask

  task automatic t_pause();
    int p;
    p = pauses;
    send(8'h0C, 8'h0F, 2'h0, 11'h040, 3'h2, 1'b1, 3'h0);
    check("pause pulses", 8'h01, 8'(pauses - p));
  endtask

  // Stage two policy with a stalling fabric
  task automatic t_policy();
    slow = 1'b1;
    send(8'h0C, 8'h0F, 2'h0, 11'h064, 3'h1, 1'b0, 3'h4);
    cfg.stp_fwd = 3'h5;
    send(8'h0C, 8'h0F, 2'h0, 11'h064, 3'h0, 1'b0, 3'h4);
    cfg = '{3'h7, 3'h7, 3'h1, 3'h4};
    send(8'h0C, 8'h0B, 2'h0, 11'h064, 3'h0, 1'b0, 3'h6);
    cfg = '{3'h7, 3'h7, 3'h0, 3'h0};
    slow = 1'b0;
  endtask

  task automatic wait_tx(input logic lvl);
    int n;
    n = 0;
    while (tx_en !== lvl && n < 5000) begin
      @(negedge clk);
      n++;
    end
    check("tx wait", 8'h00, {7'h00, n >= 5000});
  endtask

  // Counts idle cycles with carrier low until the next attempt
  task automatic quiet_run(output int g);
    int n;
    g = 0;
    n = 0;
    while (tx_en !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
      if (tx_en === 1'b0 && crs === 1'b0) g++;
    end
    check("quiet wait", 8'h00, {7'h00, n >= 5000});
  endtask

  task automatic t_tx_ok(input logic s, input int gmin);
    int g, k;
    half = 1'b0;
    spd = s;
    k = oks;
    txq_valid = 1'b1;
    wait_tx(1'b1);
    wait_tx(1'b0);
    quiet_run(g);
    txq_valid = 1'b0;
    wait_tx(1'b0);
    repeat (3) @(negedge clk);
    check("gap after frame", 8'h01, {7'h00, g >= gmin});
    check("frames sent", 8'h02, 8'(oks - k));
    spd = 1'b1;
  endtask

  task automatic t_tx_coll();
    int g, k, t;
    half = 1'b1;
    col_at = 8'h14;
    k = oks;
    t = takes;
    txq_valid = 1'b1;
    wait_tx(1'b1);
    txq_valid = 1'b0;
    wait_tx(1'b0);
    quiet_run(g);
    wait_tx(1'b0);
    col_at = 8'h00;
    repeat (3) @(negedge clk);
    check("gap after carrier", 8'h01, {7'h00, g >= 20});
    check("retry sent", 8'h01, 8'(oks - k));
    check("queue takes", 8'h01, 8'(takes - t));
  endtask

  task automatic t_tx_late();
    int k, l, hi;
    col_at = 8'h6E;
    plen = 8'h96;
    k = oks;
    l = lates;
    hi = 0;
    txq_valid = 1'b1;
    wait_tx(1'b1);
    txq_valid = 1'b0;
    wait_tx(1'b0);
    repeat (300) begin
      @(negedge clk);
      if (tx_en !== 1'b0) hi++;
    end
    check("late drops", 8'h01, 8'(lates - l));
    check("late retry", 8'h00, {7'h00, hi != 0});
    check("late sent", 8'h00, 8'(oks - k));
    check("excess drops", 8'h00, 8'(excs));
    col_at = 8'h00;
    plen = 8'h28;
    half = 1'b0;
  endtask

  task automatic t_aging();
    repeat (7 * TICK) @(negedge clk);
    send(8'h0E, 8'h0B, 2'h0, 11'h064, 3'h0, 1'b0, 3'h2);
    aging_en = 1'b1;
    repeat (7 * TICK) @(negedge clk);
    send(8'h0E, 8'h0B, 2'h0, 11'h064, 3'h0, 1'b0, 3'h6);
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_learn();
    t_migrate();
    t_errors();
    t_lengths();
    t_pause();
    t_policy();
    t_tx_ok(1'b1, 20);
    t_tx_ok(1'b0, 192);
    t_tx_coll();
    t_tx_late();
    t_aging();
    final_report();
  end
endmodule // testbench
